//--- pkg/lpm_seq_map.svh
// Offsets-free constant map: mode codes, reset value, timer widths and clock rate
`ifndef LPM_SEQ_MAP_SVH
`define LPM_SEQ_MAP_SVH
`define LPM_MODE_W 2
`define LPM_MODE_LIGHT 2'h0
`define LPM_MODE_INTER 2'h1
`define LPM_MODE_FULL 2'h2
`define LPM_MODE_RST 2'h0
`define LPM_ACT_TMR_W 32
`define LPM_TAU_TMR_W 32
`define LPM_CLK_HZ 40000000
`endif

//--- pkg/lpm_seq_pkg.sv
// Types shared by the low power mode sequencer
`default_nettype none
package lpm_seq_pkg;
   typedef enum logic [1:0] {
      MODE_LIGHT,
      MODE_INTER,
      MODE_FULL,
      MODE_NONE
   } lp_mode_t;
   typedef struct packed {
      logic sys_clk_en;
      logic mem_keep;
      logic io_hold;
      logic ram_keep;
      logic rtc_on;
      logic io_supply;
      logic timers_on;
      logic radio_on;
   } power_ctl_t;
endpackage
`default_nettype wire

//--- verif/low_power_mode_sequencer_asserts.sv
// Port checker for the low power mode sequencer
`default_nettype none
module lpm_seq_asserts (
   input wire logic core_clk_i, // Clock
   input wire logic nrst_i, // Reset, low
   input wire logic [1:0] mode_cfg_i, // Mode code
   input wire logic mode_cfg_we_i, // Mode strobe
   input wire logic main_supply_ok_i, // Main supply
   input wire logic [1:0] mode_sel_o, // Held mode
   input wire lpm_seq_pkg::power_ctl_t pwr_o, // Domains
   input wire logic io_supply_output_o, // I/O supply
   input wire logic rtc_from_backup_o, // RTC source
   input wire logic rtc_backup_charge_o, // Charge drive
   input wire logic soft_reset_o, // Reset pulse
   input wire logic send_tau_o, // Update pulse
   input wire logic asleep_o // Low power
);
   import lpm_seq_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // Low power held for two edges, outputs settled
   sequence s_low;
      asleep_o ##1 asleep_o;
   endsequence
   property p_mode_wr;
      mode_cfg_we_i |=> mode_sel_o == ($past(mode_cfg_i) == 2'h3 ? 2'h0 : $past(mode_cfg_i));
   endproperty
   property p_mode_hold;
      !mode_cfg_we_i |=> $stable(mode_sel_o);
   endproperty
   // Supply only follows an awake cycle with the main supply present
   property p_io_eq;
      io_supply_output_o |-> !$past(asleep_o) && $past(main_supply_ok_i);
   endproperty
   property p_io_off;
      s_low |-> !io_supply_output_o;
   endproperty
   property p_clk_off;
      s_low |-> !pwr_o.sys_clk_en;
   endproperty
   property p_rtc_on;
      s_low |-> pwr_o.rtc_on;
   endproperty
   property p_backup;
      rtc_from_backup_o == !main_supply_ok_i;
   endproperty
   property p_charge;
      !rtc_backup_charge_o;
   endproperty
   property p_tau_pulse;
      send_tau_o |=> !send_tau_o;
   endproperty
   property p_rst_pulse;
      soft_reset_o |=> !soft_reset_o;
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
   a_io_eq: assert property (p_io_eq) else $error("supply outside normal state");
   a_io_off: assert property (p_io_off) else $error("supply on asleep");
   a_clk_off: assert property (p_clk_off) else $error("clock on asleep");
   a_rtc_on: assert property (p_rtc_on) else $error("rtc off asleep");
   a_backup: assert property (p_backup) else $error("rtc source");
   a_charge: assert property (p_charge) else $error("backup charged");
   a_tau_pulse: assert property (p_tau_pulse) else $error("long update");
   a_rst_pulse: assert property (p_rst_pulse) else $error("long reset");
endmodule
bind low_power_mode_sequencer lpm_seq_asserts chk_u (.core_clk_i, .nrst_i, .mode_cfg_i,
   .mode_cfg_we_i, .main_supply_ok_i, .mode_sel_o, .pwr_o, .io_supply_output_o,
   .rtc_from_backup_o, .rtc_backup_charge_o, .soft_reset_o, .send_tau_o, .asleep_o);
`default_nettype wire

//--- verif/lpm_host_model.sv
// Host model driving the wake pin and ready line
`default_nettype none
module lpm_host_model (
   input wire logic clk_i, // Bench clock
   input wire logic wake_req_i, // Bench wants wake
   input wire logic rdy_req_i, // Bench wants ready
   output logic wake_pin_o = 1'b0, // Wake request pin
   output logic rdy_o = 1'b0 // Ready line
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels move only on the falling edge
   always @(negedge clk_i) begin
      wake_pin_o <= wake_req_i;
      rdy_o <= rdy_req_i;
   end
endmodule
`default_nettype wire

//--- verif/test_low_power_mode_sequencer.sv
// Self-checking bench for the low power mode sequencer
`default_nettype none
module test_low_power_mode_sequencer;
   import lpm_seq_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 0, nrst_i = 0, mode_cfg_we_i = 0, lp_enable_i = 0, psm_enable_i = 0;
   logic modem_busy_i = 1, tau_done_i = 0, main_supply_ok_i = 1, wake_req = 0, rdy_req = 0;
   logic edrx_enable_i = 0, ptw_active_i = 0, paging_occ_i = 0, ram_needed_i = 0;
   int exp_q[$]; // Model of the held mode setting, one entry per write
   logic [1:0] mode_cfg_i = 0, mode_sel_o, recommended_mode_o;
   logic io_supply_output_o, rtc_from_backup_o, rtc_backup_charge_o, soft_reset_o;
   logic send_tau_o, paging_listen_o, asleep_o;
   wire logic wake_pin_i, host_terminal_ready_i;
   power_ctl_t pwr_o;
   int num_errors = 0, samples_checked = 0, seed = 97136, n_rst = 0, n_tau = 0, i, k;
   low_power_mode_sequencer #(.ACT_CYCLES(32'h4), .TAU_CYCLES(32'h10)) dut_u (.core_clk_i,
      .nrst_i, .mode_cfg_i, .mode_cfg_we_i, .lp_enable_i, .psm_enable_i, .edrx_enable_i,
      .ptw_active_i, .paging_occ_i, .modem_busy_i, .tau_done_i, .ram_needed_i,
      .main_supply_ok_i, .wake_pin_i, .host_terminal_ready_i, .mode_sel_o, .pwr_o,
      .io_supply_output_o, .rtc_from_backup_o, .rtc_backup_charge_o, .soft_reset_o,
      .send_tau_o, .paging_listen_o, .recommended_mode_o, .asleep_o);
   lpm_host_model host_u (.clk_i(core_clk_i), .wake_req_i(wake_req), .rdy_req_i(rdy_req),
      .wake_pin_o(wake_pin_i), .rdy_o(host_terminal_ready_i));
   // 40 MHz clock
   always #12.5 core_clk_i = ~core_clk_i;
   // Pulse counters, sampled away from the launching edge
   always @(negedge core_clk_i) begin
      if (soft_reset_o === 1'b1) n_rst++;
      if (send_tau_o === 1'b1) n_tau++;
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("errors=%0d checks=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // Bounded wait for the sleep flag
   task wait_st(input logic want, input int lim);
      k = 0;
      while (asleep_o !== want && k < lim) begin
         cyc(1);
         k++;
      end
      chk(asleep_o, want);
   endtask
   // Mode write through the config strobe
   task set_mode(input int m);
      exp_q.push_back((m == 3) ? 0 : m);
      mode_cfg_i = m[1:0];
      mode_cfg_we_i = 1;
      cyc(1);
      mode_cfg_we_i = 0;
      cyc(1);
   endtask
   // Watchdog
   initial begin
      #(4000 * 25);
      num_errors++;
      test_done();
   end
   initial begin
      cyc(5);
      nrst_i = 1;
      for (i = 0; i < 20; i++) begin
         main_supply_ok_i = $random(seed);
         cyc(1);
         chk({rtc_from_backup_o, rtc_backup_charge_o}, {~main_supply_ok_i, 1'b0});
      end
      main_supply_ok_i = 1;
      for (i = 0; i < 4; i++) begin
         set_mode(i);
         chk(mode_sel_o, exp_q.pop_front());
         chk(recommended_mode_o, 0);
      end
      for (i = 0; i < 3; i++) begin
         set_mode(i);
         chk(mode_sel_o, exp_q.pop_front());
         lp_enable_i = 1;
         modem_busy_i = 0;
         ram_needed_i = $random(seed);
         n_rst = 0;
         wait_st(1, 60);
         cyc(2);
         chk({io_supply_output_o, pwr_o.sys_clk_en, pwr_o.rtc_on}, 3'h1);
         chk({pwr_o.io_hold, pwr_o.ram_keep}, {i != 2, (i == 2) ? ram_needed_i : 1'b1});
         rdy_req = 1;
         modem_busy_i = 1;
         cyc(12);
         chk(asleep_o, i != 0);
         wake_req = 1;
         wait_st(0, 20);
         tau_done_i = 1;
         cyc(6);
         chk({n_rst != 0, io_supply_output_o}, {i != 0, 1'b1});
         {tau_done_i, wake_req, rdy_req} = 0;
         cyc(4);
      end
      // eDRX: paging occasions count only inside the window
      edrx_enable_i = 1;
      ptw_active_i = 1;
      modem_busy_i = 0;
      wait_st(1, 60);
      chk({recommended_mode_o, paging_listen_o}, 3'h4);
      paging_occ_i = 1;
      cyc(1);
      paging_occ_i = 0;
      chk({asleep_o, paging_listen_o}, 2'h1);
      ptw_active_i = 0;
      cyc(1);
      chk(paging_listen_o, 0);
      wait_st(1, 60);
      paging_occ_i = 1;
      cyc(2);
      paging_occ_i = 0;
      chk(asleep_o, 1);
      {edrx_enable_i, modem_busy_i, wake_req} = 3'h3;
      wait_st(0, 20);
      wake_req = 0;
      cyc(8);
      psm_enable_i = 1;
      modem_busy_i = 0;
      wait_st(1, 60);
      n_tau = 0;
      for (i = 0; i < 4; i++) begin
         ram_needed_i = $random(seed);
         cyc(2);
         chk({pwr_o.timers_on, pwr_o.ram_keep}, {1'b1, ram_needed_i});
         chk(recommended_mode_o, 2);
      end
      for (k = 0; k < 60 && n_tau == 0; k++) cyc(1);
      chk(n_tau, 1);
      tau_done_i = 1;
      cyc(2);
      tau_done_i = 0;
      wait_st(1, 60);
      wake_req = 1;
      wait_st(0, 20);
      test_done();
   end
endmodule
`default_nettype wire

//--- verilog/low_power_mode_sequencer.sv
// Low power mode sequencer: mode selection, wake, PSM and eDRX sequencing
// Contract
// - Three low power modes, host selects
// - Light sleep stops system clock, retains state
// - Light sleep wakes on wake pin or ready
// - Intermediate keeps RTC, I/O, RAM; pin wake
// - Full keeps RTC, optional RAM; pin wake
// - Hibernate exit acts as reset
// - I/O supply only in normal operation
// - Dormant: wake on TAU expiry or pin
// - Idle active timer expiry enters dormant
// - PSM wake sends update, exchanges, idles
// - eDRX monitors only window occasions
// - Recommend light for DRX, full otherwise
// - RTC runs from backup without main supply, never charges it
`include "lpm_seq_map.svh"
`default_nettype none
module low_power_mode_sequencer #(
   parameter logic [`LPM_ACT_TMR_W-1:0] ACT_CYCLES = 32'h00000100,
   parameter logic [`LPM_TAU_TMR_W-1:0] TAU_CYCLES = 32'h00010000
) (
   input wire logic core_clk_i, // 40 MHz clock
   input wire logic nrst_i, // Synchronous reset, low
   input wire logic [1:0] mode_cfg_i, // Mode from config command
   input wire logic mode_cfg_we_i, // Config command strobe
   input wire logic lp_enable_i, // Allow entry into sleep; PSM dormant entry ignores it
   input wire logic psm_enable_i, // PSM granted by network
   input wire logic edrx_enable_i, // eDRX granted by network
   input wire logic ptw_active_i, // Paging window open
   input wire logic paging_occ_i, // Paging occasion pulse
   input wire logic modem_busy_i, // Modem traffic present
   input wire logic tau_done_i, // Update and data exchange done
   input wire logic ram_needed_i, // Modem state needs RAM in full
   input wire logic main_supply_ok_i, // Main supply present
   input wire logic wake_pin_i, // Wake request pin, async
   input wire logic host_terminal_ready_i, // Host ready line, async
   output logic [1:0] mode_sel_o, // Held mode setting
   output lpm_seq_pkg::power_ctl_t pwr_o, // Domain controls
   output logic io_supply_output_o, // I/O supply enable
   output logic rtc_from_backup_o, // RTC on backup supply
   output logic rtc_backup_charge_o, // Backup charge drive
   output logic soft_reset_o, // Reset pulse after hibernate exit
   output logic send_tau_o, // Tracking update request pulse
   output logic paging_listen_o, // Receiver monitors paging
   output logic [1:0] recommended_mode_o, // Suggested mode
   output logic asleep_o // In any low power mode
);
   import lpm_seq_pkg::*;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_IDLE,
      ST_SLEEP,
      ST_DORMANT,
      ST_WAKE_TAU
   } seq_state_t;

   // Input synchronisers, three stages each
   logic [2:0] wake_sync_r, wake_sync_nxt; // Wake pin stages
   logic [2:0] dtr_sync_r, dtr_sync_nxt; // Ready line stages
   logic wake_lvl_r, wake_lvl_nxt; // Filtered wake level
   logic dtr_lvl_r, dtr_lvl_nxt; // Filtered ready level

   always_comb begin
      wake_sync_nxt = {wake_sync_r[1:0], wake_pin_i};
      dtr_sync_nxt = {dtr_sync_r[1:0], host_terminal_ready_i};
      wake_lvl_nxt = wake_lvl_r;
      dtr_lvl_nxt = dtr_lvl_r;
      // Change counts once stages two and three agree
      if (wake_sync_r[1] == wake_sync_r[2]) begin
         wake_lvl_nxt = wake_sync_r[2];
      end
      if (dtr_sync_r[1] == dtr_sync_r[2]) begin
         dtr_lvl_nxt = dtr_sync_r[2];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wake_sync_r <= 3'h0;
         dtr_sync_r <= 3'h0;
         wake_lvl_r <= 1'b0;
         dtr_lvl_r <= 1'b0;
      end else begin
         wake_sync_r <= wake_sync_nxt;
         dtr_sync_r <= dtr_sync_nxt;
         wake_lvl_r <= wake_lvl_nxt;
         dtr_lvl_r <= dtr_lvl_nxt;
      end
   end

   // Mode setting and sequencer state
   logic [1:0] mode_cfg_r, mode_cfg_nxt; // Setting from host
   logic [1:0] mode_act_r, mode_act_nxt; // Mode latched at idle
   seq_state_t state_r, state_nxt; // Sequencer state
   logic [`LPM_ACT_TMR_W-1:0] act_cnt_r, act_cnt_nxt; // Active timer
   logic [`LPM_TAU_TMR_W-1:0] tau_cnt_r, tau_cnt_nxt; // TAU timer
   logic soft_rst_r, soft_rst_nxt; // Reset after hibernate
   logic send_tau_r, send_tau_nxt; // Update request pulse

   // Mode 3 is not a valid code; fall back to light sleep
   function automatic logic [1:0] legal_mode(input logic [1:0] m);
      legal_mode = (m == 2'h3) ? `LPM_MODE_LIGHT : m;
   endfunction

   // Wake source per mode
   function automatic logic wake_ok(input logic [1:0] m, input logic pin, input logic dtr);
      if (m == `LPM_MODE_LIGHT) begin
         wake_ok = pin | dtr;
      end else begin
         wake_ok = pin;
      end
   endfunction

   always_comb begin
      mode_cfg_nxt = mode_cfg_r;
      mode_act_nxt = mode_act_r;
      state_nxt = state_r;
      act_cnt_nxt = act_cnt_r;
      tau_cnt_nxt = tau_cnt_r;
      soft_rst_nxt = 1'b0;
      send_tau_nxt = 1'b0;
      // Host command writes the two-bit setting
      if (mode_cfg_we_i) begin
         mode_cfg_nxt = legal_mode(mode_cfg_i);
      end
      case (state_r)
         ST_ACTIVE: begin
            if (!modem_busy_i) begin
               state_nxt = ST_IDLE;
               mode_act_nxt = mode_cfg_r;
               act_cnt_nxt = ACT_CYCLES;
            end
         end
         ST_IDLE: begin
            if (modem_busy_i) begin
               state_nxt = ST_ACTIVE;
            end else if (act_cnt_r != '0) begin
               act_cnt_nxt = act_cnt_r - 1'b1;
            end else if (psm_enable_i) begin
               state_nxt = ST_DORMANT;
               tau_cnt_nxt = TAU_CYCLES;
            end else if (lp_enable_i) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // Wake source leaves; eDRX paging occasions leave only within window
            if (wake_ok(mode_act_r, wake_lvl_r, dtr_lvl_r)) begin
               state_nxt = ST_ACTIVE;
               soft_rst_nxt = (mode_act_r != `LPM_MODE_LIGHT);
            end else if (edrx_enable_i && ptw_active_i && paging_occ_i) begin
               state_nxt = ST_IDLE;
               act_cnt_nxt = ACT_CYCLES;
               soft_rst_nxt = (mode_act_r != `LPM_MODE_LIGHT);
            end
         end
         ST_DORMANT: begin
            // Entered from idle with PSM; only timer expiry or pin ends it
            if (tau_cnt_r != '0) begin
               tau_cnt_nxt = tau_cnt_r - 1'b1;
            end
            if (tau_cnt_r == '0 || wake_lvl_r) begin
               state_nxt = ST_WAKE_TAU;
               send_tau_nxt = 1'b1;
               soft_rst_nxt = (mode_act_r != `LPM_MODE_LIGHT);
            end
         end
         ST_WAKE_TAU: begin
            if (tau_done_i) begin
               state_nxt = ST_IDLE;
               mode_act_nxt = mode_cfg_r;
               act_cnt_nxt = ACT_CYCLES;
            end
         end
         default: state_nxt = ST_ACTIVE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         mode_cfg_r <= `LPM_MODE_RST;
         mode_act_r <= `LPM_MODE_RST;
         state_r <= ST_ACTIVE;
         act_cnt_r <= '0;
         tau_cnt_r <= '0;
         soft_rst_r <= 1'b0;
         send_tau_r <= 1'b0;
      end else begin
         mode_cfg_r <= mode_cfg_nxt;
         mode_act_r <= mode_act_nxt;
         state_r <= state_nxt;
         act_cnt_r <= act_cnt_nxt;
         tau_cnt_r <= tau_cnt_nxt;
         soft_rst_r <= soft_rst_nxt;
         send_tau_r <= send_tau_nxt;
      end
   end

   // Power domain controls from state and mode
   logic low_r; // In low power state
   power_ctl_t pwr_c; // Combinational domain controls
   assign low_r = (state_r == ST_SLEEP) || (state_r == ST_DORMANT);

   always_comb begin
      pwr_c = '0;
      pwr_c.rtc_on = 1'b1;
      pwr_c.timers_on = 1'b1;
      if (!low_r) begin
         pwr_c = '1;
         pwr_c.io_hold = 1'b0;
      end else if (state_r == ST_DORMANT) begin
         pwr_c.ram_keep = ram_needed_i;
      end else if (mode_act_r == `LPM_MODE_LIGHT) begin
         pwr_c.mem_keep = 1'b1;
         pwr_c.io_hold = 1'b1;
         pwr_c.ram_keep = 1'b1;
      end else if (mode_act_r == `LPM_MODE_INTER) begin
         pwr_c.io_hold = 1'b1;
         pwr_c.ram_keep = 1'b1;
      end else begin
         pwr_c.ram_keep = ram_needed_i;
      end
      pwr_c.io_supply = !low_r && main_supply_ok_i;
   end

   // Domain control outputs registered
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pwr_o <= '0;
      end else begin
         pwr_o <= pwr_c;
      end
   end

   assign mode_sel_o = mode_cfg_r;
   assign io_supply_output_o = pwr_o.io_supply;
   assign rtc_from_backup_o = !main_supply_ok_i;
   assign rtc_backup_charge_o = 1'b0;
   assign soft_reset_o = soft_rst_r;
   assign send_tau_o = send_tau_r;
   assign paging_listen_o = !low_r && (!edrx_enable_i || ptw_active_i);
   assign recommended_mode_o = (psm_enable_i || edrx_enable_i) ?
      `LPM_MODE_FULL : `LPM_MODE_LIGHT;
   assign asleep_o = low_r;
endmodule
`default_nettype wire
